// >>> verilog/oss_pkg.sv
package oss_pkg;

  // clock and link rates
  localparam int          CLK_KHZ           = 20000;
  localparam int          HS_RATE_KBPS_X100 = 75000;
  localparam int          LD_RATE_KBPS_X100 = 9375;
  localparam logic [7:0]  HS_BIT_CYCLES     = 8'(CLK_KHZ * 100 / HS_RATE_KBPS_X100);
  localparam logic [7:0]  LD_BIT_CYCLES     = 8'(CLK_KHZ * 100 / LD_RATE_KBPS_X100);

  // register byte offsets
  localparam logic [7:0]  ADDR_STATUS       = 8'h00;
  localparam logic [7:0]  ADDR_CONTROL      = 8'h04;
  localparam logic [7:0]  ADDR_OUTPUTS      = 8'h08;
  localparam logic [7:0]  ADDR_BITPER       = 8'h0C;

  // status fields
  localparam int          ST_NODE_LSB       = 0;
  localparam int          ST_MODE_BIT       = 4;
  localparam int          ST_HOLD_BIT       = 5;
  localparam int          ST_ERR_BIT        = 6;
  localparam int          ST_OK_BIT         = 7;
  localparam int          ST_STANDBY_BIT    = 8;
  localparam int          ST_SUPPLY_BIT     = 9;
  localparam int          ST_CAPT_BIT       = 10;

  // control fields
  localparam int          CTRL_EN_BIT       = 0;
  localparam logic        CTRL_EN_RESET     = 1'b1;

  typedef enum logic [2:0] {
    OSS_STANDBY = 3'b001,
    OSS_RUN     = 3'b010,
    OSS_ERROR   = 3'b100
  } oss_link_e;

  function automatic logic [7:0] oss_bit_cycles(input logic long_mode);
    oss_bit_cycles = long_mode ? LD_BIT_CYCLES : HS_BIT_CYCLES;
  endfunction

endpackage

// >>> verilog/oss_strap_latch.sv
`timescale 1ns/1ns
module oss_strap_latch #(
  parameter int W = 5
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // switch levels
  input  wire logic [W-1:0] straps_in,
  // captured copy
  output logic      [W-1:0] straps_q,
  output logic              captured
);
  logic [W-1:0] next_straps_q;
  logic         next_captured;

  // first enabled edge after release takes the switches, then never again
  always_comb begin
    next_straps_q = straps_q;
    next_captured = 1'b1;
    if (!captured) begin
      next_straps_q = straps_in;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      straps_q <= '0;
      captured <= 1'b0;
    end else if (ce) begin
      straps_q <= next_straps_q;
      captured <= next_captured;
    end
  end
endmodule

// >>> verilog/oss_output_slave.sv
// Overview of operation
// - node address equals the 4-bit hex switch code, 0 to 15 directly.
// - mode switch off: 750 kbps high speed; on: 93.75 kbps long distance.
// - master and slave modes must match; a mismatched frame counts as link failure.
// - on link error, outputs clear if hold switch off, keep values if on.
// - node address and mode switches are sampled only once after reset.
// - error indicator lit during error; link-ok dark during error or standby.
`timescale 1ns/1ns
module oss_output_slave
  import oss_pkg::*;
#(
  parameter int NOUT = 8
) (
  // clock, reset, enable
  input  wire logic            clk_sys,
  input  wire logic            resetn,
  input  wire logic            ce,
  // switches
  input  wire logic [3:0]      node_sw,
  input  wire logic            mode_sw,
  input  wire logic            hold_sw,
  // link receiver
  input  wire logic            supply_ok,
  input  wire logic            frame_ok,
  input  wire logic            frame_err,
  input  wire logic            frame_mode,
  input  wire logic [NOUT-1:0] frame_data,
  // outputs and indicators
  output logic      [NOUT-1:0] out_pins,
  output logic                 link_ok_indicator,
  output logic                 err_indicator,
  output logic                 supply_present_indicator,
  output logic      [3:0]      node_addr,
  output logic                 mode_long,
  output logic      [7:0]      bit_cycles,
  // ahb-lite slave
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic      [31:0]     hrdata,
  output logic                 hreadyout,
  output logic                 hresp
);
  import oss_pkg::*;

  logic            rst_meta;
  logic            rst_n;
  logic [4:0]      straps_q;
  logic            captured;
  oss_link_e       state;
  oss_link_e       next_state;
  logic [NOUT-1:0] next_out_pins;
  logic            next_link_ok;
  logic            next_err;
  logic            next_supply;
  logic [3:0]      next_node_addr;
  logic            next_mode_long;
  logic [7:0]      next_bit_cycles;
  logic            ctrl_en;
  logic            next_ctrl_en;
  logic            wr_pend;
  logic            next_wr_pend;
  logic [7:0]      wr_addr;
  logic [7:0]      next_wr_addr;
  logic [31:0]     next_hrdata;
  logic            good;
  logic            bad;
  logic            addr_ok;

  // release of the async reset through two flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  oss_strap_latch #(.W(5)) u_straps (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .ce        (ce),
    .straps_in ({mode_sw, node_sw}),
    .straps_q  (straps_q),
    .captured  (captured)
  );

  // frames are ignored until the switches are captured; an error pulse beats a good one
  assign good = captured && frame_ok && !frame_err && (frame_mode == straps_q[4]);
  assign bad  = captured && (frame_err || (frame_ok && frame_mode != straps_q[4]));

  // link state, outputs, indicators
  always_comb begin
    next_state      = state;
    next_out_pins   = out_pins;
    next_node_addr  = straps_q[3:0];
    next_mode_long  = straps_q[4];
    next_bit_cycles = oss_bit_cycles(straps_q[4]);
    next_supply     = supply_ok;
    case (state)
      OSS_STANDBY: begin
        if (bad) begin
          next_state = OSS_ERROR;
        end else if (good) begin
          next_state = OSS_RUN;
        end
      end
      OSS_RUN: begin
        if (bad) begin
          next_state = OSS_ERROR;
        end
      end
      OSS_ERROR: begin
        if (good) begin
          next_state = OSS_RUN;
        end
      end
      default: begin
        next_state = OSS_STANDBY;
      end
    endcase
    if (!ctrl_en) begin
      next_state = OSS_STANDBY;
    end
    if (good && ctrl_en) begin
      next_out_pins = frame_data;
    end
    // hold keeps whatever was last driven; clear wins in standby regardless
    if (next_state == OSS_STANDBY || (next_state == OSS_ERROR && !hold_sw)) begin
      next_out_pins = '0;
    end
    next_link_ok = (next_state == OSS_RUN);
    next_err     = (next_state == OSS_ERROR);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state                    <= OSS_STANDBY;
      out_pins                 <= '0;
      link_ok_indicator        <= 1'b0;
      err_indicator            <= 1'b0;
      supply_present_indicator <= 1'b0;
      node_addr                <= 4'h0;
      mode_long                <= 1'b0;
      bit_cycles               <= HS_BIT_CYCLES;
    end else if (ce) begin
      state                    <= next_state;
      out_pins                 <= next_out_pins;
      link_ok_indicator        <= next_link_ok;
      err_indicator            <= next_err;
      supply_present_indicator <= next_supply;
      node_addr                <= next_node_addr;
      mode_long                <= next_mode_long;
      bit_cycles               <= next_bit_cycles;
    end
  end

  // bus slave: zero wait states, read data fetched in the address phase
  assign addr_ok = hsel && htrans[1] && hready;

  always_comb begin
    next_wr_pend = addr_ok && hwrite;
    next_wr_addr = addr_ok ? haddr[7:0] : wr_addr;
    next_ctrl_en = ctrl_en;
    next_hrdata  = 32'h0000_0000;
    if (wr_pend && wr_addr == ADDR_CONTROL) begin
      next_ctrl_en = hwdata[CTRL_EN_BIT];
    end
    if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        ADDR_STATUS: begin
          next_hrdata[ST_NODE_LSB +: 4] = node_addr;
          next_hrdata[ST_MODE_BIT]      = mode_long;
          next_hrdata[ST_HOLD_BIT]      = hold_sw;
          next_hrdata[ST_ERR_BIT]       = err_indicator;
          next_hrdata[ST_OK_BIT]        = link_ok_indicator;
          next_hrdata[ST_STANDBY_BIT]   = (state == OSS_STANDBY);
          next_hrdata[ST_SUPPLY_BIT]    = supply_present_indicator;
          next_hrdata[ST_CAPT_BIT]      = captured;
        end
        ADDR_CONTROL: begin
          next_hrdata[CTRL_EN_BIT] = ctrl_en;
        end
        ADDR_OUTPUTS: begin
          next_hrdata[NOUT-1:0] = out_pins;
        end
        ADDR_BITPER: begin
          next_hrdata[7:0] = bit_cycles;
        end
        default: begin
          next_hrdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // hsize is ignored: every register is a whole word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en   <= CTRL_EN_RESET;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      ctrl_en   <= next_ctrl_en;
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  property p_node_from_switch;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && captured |=> node_addr == $past(straps_q[3:0]);
  endproperty
  a_node_from_switch: assert property (p_node_from_switch)
    else $error("node address differs from switch code");

  property p_rate_by_mode;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && captured ##1 ce |=> bit_cycles == oss_bit_cycles(mode_long);
  endproperty
  a_rate_by_mode: assert property (p_rate_by_mode)
    else $error("bit period does not follow mode");

  property p_mismatch_fails;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && ctrl_en && captured && frame_ok && frame_mode != straps_q[4]
      |=> err_indicator && !link_ok_indicator;
  endproperty
  a_mismatch_fails: assert property (p_mismatch_fails)
    else $error("mode mismatch not treated as failure");

  property p_clear_on_error;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && bad && !hold_sw |=> out_pins == '0;
  endproperty
  a_clear_on_error: assert property (p_clear_on_error)
    else $error("outputs not cleared on error");

  property p_hold_on_error;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && ctrl_en && bad && hold_sw && state != OSS_STANDBY |=> $stable(out_pins);
  endproperty
  a_hold_on_error: assert property (p_hold_on_error)
    else $error("outputs changed while held");

  property p_switch_once;
    @(posedge clk_sys) disable iff (!rst_n)
      captured && $past(captured) |-> $stable(straps_q);
  endproperty
  a_switch_once: assert property (p_switch_once)
    else $error("switches resampled after capture");

  property p_indicators;
    @(posedge clk_sys) disable iff (!rst_n)
      (err_indicator |-> !link_ok_indicator) and
      (state == OSS_STANDBY |-> !link_ok_indicator && !err_indicator);
  endproperty
  a_indicators: assert property (p_indicators)
    else $error("indicator pattern illegal");

  c_run: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state == OSS_STANDBY ##1 state == OSS_RUN);
  c_hold: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state == OSS_ERROR && hold_sw && out_pins != '0);
  c_recover: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state == OSS_ERROR ##1 state == OSS_RUN);
endmodule

// >>> test/oss_master_model.sv
`timescale 1ns/1ns
module oss_master_model #(
  parameter int NOUT = 8
) (
  // clock
  input  wire logic            clk_sys,
  // frame events
  output logic                 frame_ok,
  output logic                 frame_err,
  output logic                 frame_mode,
  output logic      [NOUT-1:0] frame_data
);
  initial begin
    frame_ok   = 1'b0;
    frame_err  = 1'b0;
    frame_mode = 1'b0;
    frame_data = '0;
  end
  // frames only ever go to the node this slave answers to
  task automatic send(input logic good, input logic md, input logic [NOUT-1:0] d);
    @(posedge clk_sys);
    frame_ok   <= good;
    frame_err  <= !good;
    frame_mode <= md;
    frame_data <= d;
    @(posedge clk_sys);
    frame_ok   <= 1'b0;
    frame_err  <= 1'b0;
    // released lines show junk, never the last word
    frame_mode <= !md;
    frame_data <= ~d;
  endtask
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ns
module testbench;
  import oss_pkg::*;
  logic        clk_sys = 1'b0, resetn = 1'b0, ce = 1'b1;
  logic [3:0]  node_sw = 4'h0, node_addr, nd;
  logic        mode_sw = 1'b0, hold_sw = 1'b0, supply_ok = 1'b0, md;
  logic        frame_ok, frame_err, frame_mode, mode_long;
  logic [7:0]  frame_data, out_pins, bit_cycles, d;
  logic        link_ok_indicator, err_indicator, supply_present_indicator;
  logic        hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  int          err_count = 0, total_checks = 0, seed;

  always #25 clk_sys = ~clk_sys;

  oss_output_slave u_dut (
    .clk_sys, .resetn, .ce, .node_sw, .mode_sw, .hold_sw, .supply_ok, .frame_ok,
    .frame_err, .frame_mode, .frame_data, .out_pins, .link_ok_indicator,
    .err_indicator, .supply_present_indicator, .node_addr, .mode_long, .bit_cycles,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp
  );
  oss_master_model u_mst (.clk_sys, .frame_ok, .frame_err, .frame_mode, .frame_data);

  function automatic logic [7:0] bc(input logic m);
    bc = m ? 8'(2000000 / 9375) : 8'(2000000 / 75000);
  endfunction

  // st is {standby, link ok, error}
  function automatic logic [31:0] stat(input logic [2:0] st, input logic h, input logic p);
    stat = {21'h0, 1'b1, p, st, h, md, nd};
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // wait for the slave's ready; only the watchdog bounds it
  task automatic wt;
    do begin
      @(posedge clk_sys);
    end while (hreadyout !== 1'b1);
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= 32'(a);
    wt();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wt();
    rd = hrdata;
    chk("hresp", hresp, 32'h0);
  endtask

  task automatic frame(input logic g, input logic m, input logic [7:0] dd);
    u_mst.send(g, m, dd);
    @(posedge clk_sys);
  endtask

  task automatic outs(input logic [7:0] o, input logic k, input logic e);
    chk("out_pins", out_pins, o);
    chk("link_ok", link_ok_indicator, k);
    chk("err_ind", err_indicator, e);
  endtask

  task automatic rst(input logic [3:0] n, input logic m);
    node_sw <= n;
    mode_sw <= m;
    resetn  <= 1'b0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (5) @(posedge clk_sys);
  endtask

  initial begin
    seed = 32'h7e9c;
    for (int i = 0; i < 16; i++) begin
      nd = 4'(i);
      md = 1'($random(seed));
      rst(nd, md);
      chk("node_addr", node_addr, nd);
      chk("mode_long", mode_long, md);
      chk("bit_cycles", bit_cycles, bc(md));
      node_sw <= ~nd;
      mode_sw <= ~md;
      repeat (3) @(posedge clk_sys);
      chk("latched", {mode_long, node_addr}, {md, nd});
    end
    outs(8'h00, 1'b0, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("status", rd, stat(3'b100, 1'b0, 1'b0));
    bus(1'b0, ADDR_CONTROL, 32'h0);
    chk("control", rd, 32'h1);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'b0, ADDR_BITPER, 32'h0);
    chk("bitper", rd, 32'(bc(md)));
    // hold on/off crossed with error frame and mode mismatch
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      hold_sw   <= i[0];
      supply_ok <= i[2];
      frame(1'b1, md, d);
      outs(d, 1'b1, 1'b0);
      frame(i[1], i[1] ? !md : md, ~d);
      outs(i[0] ? d : 8'h00, 1'b0, 1'b1);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("status", rd, stat(3'b001, i[0], i[2]));
      chk("supply", supply_present_indicator, 32'(i[2]));
    end
    frame(1'b1, md, 8'hA5);
    outs(8'hA5, 1'b1, 1'b0);
    bus(1'b1, ADDR_CONTROL, 32'h0);
    repeat (2) @(posedge clk_sys);
    outs(8'h00, 1'b0, 1'b0);
    frame(1'b1, md, 8'h3C);
    outs(8'h00, 1'b0, 1'b0);
    bus(1'b1, ADDR_CONTROL, 32'h1);
    frame(1'b1, md, 8'hC3);
    outs(8'hC3, 1'b1, 1'b0);
    // clock enable low: a frame in that time must leave everything frozen
    ce <= 1'b0;
    frame(1'b1, md, 8'h5A);
    outs(8'hC3, 1'b1, 1'b0);
    ce <= 1'b1;
    conclude();
  end

  // whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    conclude();
  end
endmodule
